/* File: hdl/mpu_host_if.v */
// Contract
// - Decode strap into five interface modes.
// - Chip select gates all modes but two-wire.
// - Chip select high releases all data lines in the chip-selected modes.
// - Serial 3-line and two-wire ignore command select.
// - 8080 mode latches on write strobe rise.
// - 6800 mode latches on enable fall.
// - SPI data bit 7, clock bit 6.
// - Two-wire clock bit 7, data, acknowledge.
// - Bits 1 and 0 are slave address.
`timescale 1ns/10ps
`include "mpu_if_defs.vh"

module mpu_host_if #(
    // Upper five bits of the two-wire address; the default is arbitrary.
    parameter [`TWI_ADDR_HI_W-1:0] TWI_ADDR_HI = `TWI_ADDR_HI_RESET
) (
    // Clock and synchronous active-low reset.
    input wire CLOCK,
    input wire RSTN,
    // Host pins.
    input wire [2:0] INTERFACE_SELECT,
    input wire CHIP_SELECT_N,
    input wire CMD_DATA_SELECT,
    input wire WRITE_STROBE_OR_DIR,
    input wire ENABLE_OR_READ_STROBE,
    input wire [7:0] HOST_DATA_BUS_IN,
    output reg [7:0] HOST_DATA_BUS_OUT,
    output reg [7:0] HOST_DATA_BUS_OE,
    // Received byte stream toward the controller core.
    output wire BYTE_VALID,
    output wire [7:0] BYTE_DATA,
    output wire BYTE_IS_DATA,
    input wire BYTE_READY,
    // Status.
    output reg [`MODE_W-1:0] MODE,
    output reg INIT_ACTIVE,
    output reg BUSY,
    output reg OVERRUN
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge history
    // ------------------------------------------------------------------
    reg [13:0] pin_meta_reg; // First stage, read only by the second.
    reg [13:0] pin_sync_reg; // Second stage, safe for logic.
    reg [13:0] pin_prev_reg; // Previous safe value, for edge detection.

    // Named views of the synchronised pins.
    wire [7:0] db = pin_sync_reg[7:0];
    wire cs_n = pin_sync_reg[8];
    wire a0 = pin_sync_reg[9];
    wire wr_dir = pin_sync_reg[10];
    wire en_rd = pin_sync_reg[11];
    wire [1:0] ps_lo = pin_sync_reg[13:12];

    // Strobe edges, seen after the synchroniser.
    wire wr_rise = wr_dir && !pin_prev_reg[10];
    wire en_fall = !en_rd && pin_prev_reg[11];
    wire spi_clk_rise = db[`SPI_CLK_BIT] && !pin_prev_reg[`SPI_CLK_BIT];
    wire scl = db[`TWI_CLK_BIT];
    wire scl_rise = scl && !pin_prev_reg[`TWI_CLK_BIT];
    wire scl_fall = !scl && pin_prev_reg[`TWI_CLK_BIT];
    wire sda = db[`TWI_DATA_BIT];
    wire sda_prev = pin_prev_reg[`TWI_DATA_BIT];

    reg ps2_meta_reg; // Strap bit 2, first stage.
    reg ps2_sync_reg; // Strap bit 2, second stage.

    // All pins come from the host's timing, so every one is synchronised.
    // Data passes the same two stages as the strobes, so the byte taken at
    // a strobe edge is the one the host held while the strobe moved.
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            // Data lines reset high, their idle level, so no false edge follows.
            pin_meta_reg <= 14'h0fff;
            pin_sync_reg <= 14'h0fff;
            pin_prev_reg <= 14'h0fff;
            ps2_meta_reg <= 1'b0;
            ps2_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {INTERFACE_SELECT[1:0], ENABLE_OR_READ_STROBE,
                WRITE_STROBE_OR_DIR, CMD_DATA_SELECT, CHIP_SELECT_N, HOST_DATA_BUS_IN};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
            ps2_meta_reg <= INTERFACE_SELECT[2];
            ps2_sync_reg <= ps2_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    reg [`MODE_W-1:0] mode_next; // Decoded strap.

    // Unlisted strap codes select no interface, so nothing is accepted.
    always @* begin
        case ({ps2_sync_reg, ps_lo})
            `MODE_CODE_8080: mode_next = `MODE_8080;
            `MODE_CODE_6800: mode_next = `MODE_6800;
            `MODE_CODE_SER3: mode_next = `MODE_SER3;
            `MODE_CODE_SER4: mode_next = `MODE_SER4;
            `MODE_CODE_TWI: mode_next = `MODE_TWI;
            default: mode_next = `MODE_NONE;
        endcase
    end

    wire m_8080 = MODE[1];
    wire m_6800 = MODE[2];
    wire m_ser3 = MODE[3];
    wire m_ser4 = MODE[4];
    wire m_twi = MODE[5];

    // Chip select gates every mode except two-wire.
    wire port_on = !cs_n;

    // ------------------------------------------------------------------
    // SPI shifter (3-line and 4-line)
    // ------------------------------------------------------------------
    reg [7:0] spi_shift_reg; // Bits gathered so far, MSB first.
    reg [3:0] spi_count_reg; // Bits gathered in the current byte.
    wire [7:0] spi_byte = {spi_shift_reg[6:0], db[`SPI_DATA_BIT]};
    wire spi_mode = m_ser3 || m_ser4;
    wire spi_done = spi_mode && port_on && spi_clk_rise
        && (spi_count_reg == `BITS_PER_BYTE - 4'h1);

    // Chip select high drops a partial byte; the next byte starts clean.
    always @(posedge CLOCK) begin
        if (!RSTN || !spi_mode || !port_on) begin
            spi_shift_reg <= 8'h00;
            spi_count_reg <= 4'h0;
        end else if (spi_clk_rise) begin
            spi_shift_reg <= spi_byte;
            spi_count_reg <= spi_done ? 4'h0 : spi_count_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Two-wire receiver: start, address, control byte, then payload
    // ------------------------------------------------------------------
    localparam [2:0] T_IDLE = 3'h1; // Waiting for a start condition.
    localparam [2:0] T_ADDR = 3'h2; // Receiving the address byte.
    localparam [2:0] T_DATA = 3'h4; // Receiving control or payload bytes.

    reg [2:0] twi_state_reg; // Receiver state.
    reg [2:0] twi_state_next;
    reg [7:0] twi_shift_reg; // Bits of the current byte.
    reg [3:0] twi_count_reg; // Bits received; eight means in acknowledge.
    reg twi_ack_reg; // Acknowledge is being driven.
    reg twi_ctrl_seen_reg; // Control byte already taken.
    reg twi_dc_reg; // Display/command flag from the control byte.
    reg twi_push; // Payload byte complete this cycle.

    wire twi_start = m_twi && scl && sda_prev && !sda;
    wire twi_stop = m_twi && scl && !sda_prev && sda;
    wire twi_byte_end = scl_fall && (twi_count_reg == `BITS_PER_BYTE) && !twi_ack_reg;
    // Address: five fixed bits, two strap bits, then a write direction bit.
    wire twi_match = (twi_shift_reg[7:1] == {TWI_ADDR_HI, db[1:0]})
        && !twi_shift_reg[0];

    // Next state and payload push for the receiver.
    always @* begin
        twi_state_next = twi_state_reg;
        twi_push = 1'b0;
        case (twi_state_reg)
            T_IDLE: begin
                twi_state_next = T_IDLE;
            end
            T_ADDR: begin
                // A foreign address idles the receiver until a new start.
                if (twi_byte_end) begin
                    twi_state_next = twi_match ? T_DATA : T_IDLE;
                end
            end
            T_DATA: begin
                twi_push = twi_byte_end && twi_ctrl_seen_reg;
            end
            default: begin
                twi_state_next = T_IDLE;
            end
        endcase
        if (!m_twi || twi_stop) begin
            twi_state_next = T_IDLE;
        end else if (twi_start) begin
            twi_state_next = T_ADDR;
        end
    end

    // Bit counting, shifting and the acknowledge window.
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            twi_state_reg <= T_IDLE;
            twi_shift_reg <= 8'h00;
            twi_count_reg <= 4'h0;
            twi_ack_reg <= 1'b0;
            twi_ctrl_seen_reg <= 1'b0;
            twi_dc_reg <= 1'b1;
        end else begin
            twi_state_reg <= twi_state_next;
            if (twi_start || twi_stop || !m_twi) begin
                twi_count_reg <= 4'h0;
                twi_ack_reg <= 1'b0;
                twi_ctrl_seen_reg <= 1'b0;
            end else if (twi_state_reg != T_IDLE) begin
                if (scl_rise && twi_count_reg != `BITS_PER_BYTE) begin
                    twi_shift_reg <= {twi_shift_reg[6:0], sda};
                    twi_count_reg <= twi_count_reg + 4'h1;
                end else if (scl_fall && twi_ack_reg) begin
                    // Acknowledge clock over: release and start the next byte.
                    twi_ack_reg <= 1'b0;
                    twi_count_reg <= 4'h0;
                end else if (twi_byte_end) begin
                    twi_ack_reg <= (twi_state_reg == T_DATA) || twi_match;
                    if (twi_state_reg == T_DATA && !twi_ctrl_seen_reg) begin
                        twi_ctrl_seen_reg <= 1'b1;
                        twi_dc_reg <= twi_shift_reg[`TWI_CTRL_DC_BIT];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte source selection
    // ------------------------------------------------------------------
    reg push_valid; // One byte to store this cycle.
    reg [`FIFO_WIDTH-1:0] push_word; // {display flag, byte}.

    // Only one mode is live, so at most one source fires in a cycle.
    always @* begin
        push_valid = 1'b0;
        push_word = {1'b0, db};
        if (m_8080 && port_on && wr_rise) begin
            push_valid = 1'b1;
            push_word = {a0, db};
        end else if (m_6800 && port_on && en_fall && !wr_dir) begin
            // A read cycle is never served: display memory has no readback.
            push_valid = 1'b1;
            push_word = {a0, db};
        end else if (spi_done) begin
            // Three-line bytes are display data; the select pin is ignored.
            push_word = {m_ser4 ? a0 : 1'b1, spi_byte};
            push_valid = 1'b1;
        end else if (twi_push) begin
            push_valid = 1'b1;
            push_word = {twi_dc_reg, twi_shift_reg};
        end
    end

    // ------------------------------------------------------------------
    // Byte FIFO toward the core
    // ------------------------------------------------------------------
    wire fifo_in_ready; // Room for another byte.
    wire [`FIFO_WIDTH-1:0] fifo_out_word; // Head word.

    // The host cannot be stalled, so back-pressure shows as BUSY and a
    // byte arriving while full is dropped and flagged.
    byte_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .ADDR_W(`FIFO_ADDR_W)
    ) u_fifo (
        .clk(CLOCK),
        .rst_n(RSTN),
        .in_valid(push_valid),
        .in_data(push_word),
        .in_ready(fifo_in_ready),
        .out_valid(BYTE_VALID),
        .out_data(fifo_out_word),
        .out_ready(BYTE_READY)
    );

    assign BYTE_DATA = fifo_out_word[7:0];
    assign BYTE_IS_DATA = fifo_out_word[8];

    // ------------------------------------------------------------------
    // Status outputs and the data bus drivers
    // ------------------------------------------------------------------
    // Reset returns mode, flags and every shifter to defaults.
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            MODE <= `MODE_NONE;
            INIT_ACTIVE <= 1'b1;
            BUSY <= 1'b0;
            OVERRUN <= 1'b0;
            HOST_DATA_BUS_OUT <= 8'h00;
            HOST_DATA_BUS_OE <= 8'h00;
        end else begin
            MODE <= mode_next;
            INIT_ACTIVE <= 1'b0;
            BUSY <= !fifo_in_ready;
            if (push_valid && !fifo_in_ready) begin
                OVERRUN <= 1'b1;
            end
            // The device never returns data; only acknowledge is driven low.
            HOST_DATA_BUS_OUT <= 8'h00;
            // Outside two-wire acknowledge every line floats, which covers
            // chip select high in all chip-selected modes.
            HOST_DATA_BUS_OE <= (m_twi && twi_ack_reg) ? 8'h0c : 8'h00;
        end
    end

endmodule // mpu_host_if

/* File: inc/mpu_if_defs.vh */
`ifndef MPU_IF_DEFS_VH
`define MPU_IF_DEFS_VH

// ----------------------------------------------------------------------
// Interface-select strap codes, ordered {bit2, bit1, bit0}.
// ----------------------------------------------------------------------
`define MODE_CODE_8080 3'h1
`define MODE_CODE_6800 3'h3
`define MODE_CODE_SER3 3'h0
`define MODE_CODE_SER4 3'h2
`define MODE_CODE_TWI 3'h4

// ----------------------------------------------------------------------
// One-hot mode register encoding and its reset value.
// ----------------------------------------------------------------------
`define MODE_W 6
`define MODE_NONE 6'h01
`define MODE_8080 6'h02
`define MODE_6800 6'h04
`define MODE_SER3 6'h08
`define MODE_SER4 6'h10
`define MODE_TWI 6'h20

// ----------------------------------------------------------------------
// Host data bus pin positions in the serial modes.
// ----------------------------------------------------------------------
`define SPI_DATA_BIT 7
`define SPI_CLK_BIT 6
`define TWI_CLK_BIT 7
`define TWI_DATA_BIT 6
`define TWI_ACK_HI 3
`define TWI_ACK_LO 2

// ----------------------------------------------------------------------
// Byte framing and two-wire address layout.
// ----------------------------------------------------------------------
`define BITS_PER_BYTE 4'h8
`define TWI_ADDR_HI_W 5
`define TWI_ADDR_HI_RESET 5'h0f
`define TWI_CTRL_DC_BIT 6

// ----------------------------------------------------------------------
// Byte FIFO shape: one display/command flag plus eight data bits.
// ----------------------------------------------------------------------
`define FIFO_WIDTH 9
`define FIFO_DEPTH 8
`define FIFO_ADDR_W 3

`endif

/* File: hdl/byte_fifo.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Small synchronous FIFO with a registered head word.
// ----------------------------------------------------------------------
module byte_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter ADDR_W = 3
) (
    // Clock and synchronous active-low reset.
    input wire clk,
    input wire rst_n,
    // Filling side.
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    // Draining side.
    output reg out_valid,
    output reg [WIDTH-1:0] out_data,
    input wire out_ready
);

    // Storage count value that means the array is full.
    localparam [ADDR_W:0] FULL_COUNT = DEPTH;

    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array.
    reg [ADDR_W-1:0] wr_ptr_reg; // Next slot to write.
    reg [ADDR_W-1:0] rd_ptr_reg; // Next slot to read.
    reg [ADDR_W:0] count_reg; // Words held in the array.

    wire push; // A word enters this cycle.
    wire pop; // A word moves from the array to the head register.

    // Full is honest: the head register is extra room, not counted here.
    assign in_ready = (count_reg != FULL_COUNT);
    assign push = in_valid && in_ready;
    assign pop = (count_reg != {(ADDR_W+1){1'b0}}) && (!out_valid || out_ready);

    // ------------------------------------------------------------------
    // Array write port; storage needs no reset.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // ------------------------------------------------------------------
    // Pointers, count and the registered head word.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= {ADDR_W{1'b0}};
            rd_ptr_reg <= {ADDR_W{1'b0}};
            count_reg <= {(ADDR_W+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                // The head register loads only when it is empty or drained.
                rd_ptr_reg <= rd_ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
                out_data <= mem[rd_ptr_reg];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !pop) begin
                count_reg <= count_reg + {{ADDR_W{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_reg <= count_reg - {{ADDR_W{1'b0}}, 1'b1};
            end
        end
    end

endmodule // byte_fifo

/* File: test/mpu_host_if_chk.sv */
`timescale 1ns/10ps
`include "mpu_if_defs.vh"

// ----------------------------------------------------------------------
// Port-level checker for the host interface front end.
// ----------------------------------------------------------------------
module mpu_host_if_chk (
    // Clock and reset.
    input wire CLOCK,
    input wire RSTN,
    // Host pins.
    input wire [2:0] INTERFACE_SELECT,
    input wire CHIP_SELECT_N,
    input wire CMD_DATA_SELECT,
    input wire WRITE_STROBE_OR_DIR,
    input wire ENABLE_OR_READ_STROBE,
    input wire [7:0] HOST_DATA_BUS_IN,
    input wire [7:0] HOST_DATA_BUS_OUT,
    input wire [7:0] HOST_DATA_BUS_OE,
    // Byte stream.
    input wire BYTE_VALID,
    input wire [7:0] BYTE_DATA,
    input wire BYTE_IS_DATA,
    input wire BYTE_READY,
    // Status.
    input wire [`MODE_W-1:0] MODE,
    input wire INIT_ACTIVE,
    input wire BUSY,
    input wire OVERRUN
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    // Strap decode, written apart from the design so a swapped row shows up.
    function automatic logic [`MODE_W-1:0] dec(input logic [2:0] s);
        case (s)
            `MODE_CODE_8080: dec = `MODE_8080;
            `MODE_CODE_6800: dec = `MODE_6800;
            `MODE_CODE_SER3: dec = `MODE_SER3;
            `MODE_CODE_SER4: dec = `MODE_SER4;
            `MODE_CODE_TWI: dec = `MODE_TWI;
            default: dec = `MODE_NONE;
        endcase
    endfunction

    a_mode_follows_strap: assert property ($stable(INTERFACE_SELECT) [*6] |->
        MODE == dec(INTERFACE_SELECT)) else $error("mode does not match strap");
    a_mode_one_hot: assert property ($onehot(MODE))
        else $error("mode is not one-hot");
    a_bus_float: assert property (MODE != `MODE_TWI |-> HOST_DATA_BUS_OE == 8'h00)
        else $error("data bus driven outside two-wire mode");
    a_ack_lanes: assert property (HOST_DATA_BUS_OE == 8'h00 || HOST_DATA_BUS_OE == 8'h0c)
        else $error("acknowledge on wrong lanes");
    a_ack_low: assert property (HOST_DATA_BUS_OUT == 8'h00)
        else $error("acknowledge level not low");
    a_reset_state: assert property ($rose(RSTN) |-> MODE == `MODE_NONE && INIT_ACTIVE
        && !BUSY && !OVERRUN && !BYTE_VALID) else $error("reset state wrong");
    a_init_drops: assert property ($rose(RSTN) |=> !INIT_ACTIVE)
        else $error("init flag stays high");
    a_byte_holds: assert property (BYTE_VALID && !BYTE_READY |=> BYTE_VALID
        && $stable(BYTE_DATA) && $stable(BYTE_IS_DATA)) else $error("byte not held");
    a_overrun_sticky: assert property (OVERRUN |=> OVERRUN)
        else $error("overrun flag cleared");

    // Main scenarios seen from the ports.
    c_byte_out: cover property ($rose(BYTE_VALID));
    c_full: cover property ($rose(BUSY));
    c_overrun: cover property ($rose(OVERRUN));
    c_ack: cover property (HOST_DATA_BUS_OE == 8'h0c);
endmodule // mpu_host_if_chk

bind mpu_host_if mpu_host_if_chk u_mpu_host_if_chk (.CLOCK(CLOCK), .RSTN(RSTN),
    .INTERFACE_SELECT(INTERFACE_SELECT), .CHIP_SELECT_N(CHIP_SELECT_N),
    .CMD_DATA_SELECT(CMD_DATA_SELECT), .WRITE_STROBE_OR_DIR(WRITE_STROBE_OR_DIR),
    .ENABLE_OR_READ_STROBE(ENABLE_OR_READ_STROBE), .HOST_DATA_BUS_IN(HOST_DATA_BUS_IN),
    .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT), .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
    .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA), .BYTE_IS_DATA(BYTE_IS_DATA),
    .BYTE_READY(BYTE_READY), .MODE(MODE), .INIT_ACTIVE(INIT_ACTIVE), .BUSY(BUSY),
    .OVERRUN(OVERRUN));

/* File: test/host_bus_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Microprocessor model: parallel writes and serial bytes, 4 cycles a phase.
// ----------------------------------------------------------------------
module host_bus_model (
    // Clock.
    input wire clk,
    // Host pins driven toward the device.
    output logic cs_n,
    output logic a0,
    output logic wr_dir,
    output logic en_rd,
    output logic [7:0] bus,
    // Acknowledge enables seen from the device.
    input wire [7:0] oe
);
    // Idle: deselected, strobes parked high, select parked high.
    initial begin
        cs_n = 1'b1;
        a0 = 1'b1;
        wr_dir = 1'b1;
        en_rd = 1'b1;
        bus = 8'hff;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One parallel write; m6 picks the 6800 cycle, rw is its direction pin.
    task automatic wr(input logic m6, input logic a, input logic [7:0] d,
            input logic c, input logic rw);
        wr_dir <= m6 ? 1'b0 : 1'b1;
        en_rd <= m6 ? 1'b0 : 1'b1;
        a0 <= a;
        bus <= d;
        step(4);
        // Select only once the strobe is parked, so parking is never taken as an edge.
        cs_n <= c;
        if (m6) begin
            wr_dir <= rw;
            en_rd <= 1'b1;
        end else begin
            wr_dir <= 1'b0;
        end
        step(4);
        if (m6) en_rd <= 1'b0;
        else wr_dir <= 1'b1;
        step(4);
        // Hold time is over: the bus no longer shows the byte.
        wr_dir <= m6 ? 1'b0 : 1'b1;
        bus <= ~d;
        cs_n <= 1'b1;
        a0 <= 1'b1;
        step(4);
    endtask

    // One serial byte, MSB first, clock idles low between frames.
    task automatic spi(input logic a, input logic [7:0] d);
        cs_n <= 1'b0;
        a0 <= a;
        for (int i = 7; i >= 0; i--) begin
            bus <= {d[i], 1'b0, 6'h3f};
            step(4);
            bus <= {d[i], 1'b1, 6'h3f};
            step(4);
        end
        bus <= {~d[0], 1'b0, 6'h3f};
        step(4);
        cs_n <= 1'b1;
        a0 <= 1'b1;
        step(4);
    endtask

    // Two-wire levels: clock on bit 7, data joined on bits 6 to 2, straps 2'b10.
    function automatic logic [7:0] tw(input logic c, input logic s);
        return {c, {5{s}}, 2'b10};
    endfunction

    // One two-wire frame of three bytes; chip select stays high throughout.
    task automatic twi(input logic [23:0] f, output logic [2:0] acks);
        bus <= tw(1'b1, 1'b1);
        step(4);
        bus <= tw(1'b1, 1'b0);
        step(4);
        for (int i = 23; i >= 0; i--) begin
            bus <= tw(1'b0, f[i]);
            step(4);
            bus <= tw(1'b1, f[i]);
            step(4);
            if (i % 8 == 0) begin
                // Released data reads high; the answer shows on the enables.
                bus <= tw(1'b0, 1'b1);
                step(4);
                bus <= tw(1'b1, 1'b1);
                step(2);
                acks[i / 8] = (oe == 8'h0c);
                step(2);
            end
        end
        bus <= tw(1'b0, 1'b0);
        step(4);
        bus <= tw(1'b1, 1'b0);
        step(4);
        bus <= tw(1'b1, 1'b1);
        step(4);
    endtask
endmodule // host_bus_model

/* File: test/testbench.sv */
`timescale 1ns/10ps
`include "mpu_if_defs.vh"

// ----------------------------------------------------------------------
// Self-checking bench: one task per scenario.
// ----------------------------------------------------------------------
module testbench;
    logic clk = 1'b0; // 200 MHz system clock.
    logic rstn = 1'b0; // Active-low reset.
    logic [2:0] strap = 3'h1; // Interface strap.
    logic ready = 1'b0; // Core-side acceptance.
    wire cs_n, a0, wr_dir, en_rd;
    wire [7:0] bus, bus_out, bus_oe, bdata;
    wire bvalid, bis_data, init_act, busy, overrun;
    wire [`MODE_W-1:0] mode;
    int miscompares = 0;
    int num_checks = 0;

    initial forever #2.5 clk = ~clk;

    host_bus_model u_host_bus_model (.clk(clk), .cs_n(cs_n), .a0(a0), .wr_dir(wr_dir),
        .en_rd(en_rd), .bus(bus), .oe(bus_oe));
    mpu_host_if u_mpu_host_if (.CLOCK(clk), .RSTN(rstn), .INTERFACE_SELECT(strap),
        .CHIP_SELECT_N(cs_n), .CMD_DATA_SELECT(a0), .WRITE_STROBE_OR_DIR(wr_dir),
        .ENABLE_OR_READ_STROBE(en_rd), .HOST_DATA_BUS_IN(bus), .HOST_DATA_BUS_OUT(bus_out),
        .HOST_DATA_BUS_OE(bus_oe), .BYTE_VALID(bvalid), .BYTE_DATA(bdata),
        .BYTE_IS_DATA(bis_data), .BYTE_READY(ready), .MODE(mode), .INIT_ACTIVE(init_act),
        .BUSY(busy), .OVERRUN(overrun));

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Reset for 8 cycles with the given strap, then let the synchronisers fill.
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        strap <= s;
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask

    // Wait for a byte, compare flag and value, then accept it for one cycle.
    task automatic take(input logic f, input logic [7:0] d);
        int i;
        for (i = 0; i < 60 && bvalid !== 1'b1; i++) @(posedge clk) #1;
        check({bis_data, bdata}, {f, d});
        check(bvalid, 1'b1);
        @(posedge clk) ready <= 1'b1;
        @(posedge clk) ready <= 1'b0;
        #1;
    endtask

    task automatic t_modes();
        logic [2:0] codes[6] = '{`MODE_CODE_8080, `MODE_CODE_6800, `MODE_CODE_SER3,
            `MODE_CODE_SER4, `MODE_CODE_TWI, 3'h7};
        logic [5:0] exp[6] = '{`MODE_8080, `MODE_6800, `MODE_SER3, `MODE_SER4,
            `MODE_TWI, `MODE_NONE};
        for (int i = 0; i < 6; i++) begin
            do_reset(codes[i]);
            check(mode, exp[i]);
            check({init_act, bvalid, bus_oe}, 9'h0);
        end
    endtask

    task automatic t_8080();
        do_reset(`MODE_CODE_8080);
        u_host_bus_model.wr(1'b0, 1'b1, 8'ha5, 1'b0, 1'b0);
        take(1'b1, 8'ha5);
        u_host_bus_model.wr(1'b0, 1'b0, 8'h3c, 1'b0, 1'b0);
        take(1'b0, 8'h3c);
        u_host_bus_model.wr(1'b0, 1'b1, 8'h77, 1'b1, 1'b0);
        repeat (10) @(posedge clk);
        check({bvalid, bus_oe}, 9'h0);
    endtask

    task automatic t_6800();
        do_reset(`MODE_CODE_6800);
        u_host_bus_model.wr(1'b1, 1'b1, 8'h5a, 1'b0, 1'b0);
        take(1'b1, 8'h5a);
        u_host_bus_model.wr(1'b1, 1'b1, 8'h11, 1'b0, 1'b1);
        u_host_bus_model.wr(1'b1, 1'b0, 8'hc3, 1'b0, 1'b0);
        take(1'b0, 8'hc3);
    endtask

    task automatic t_serial();
        do_reset(`MODE_CODE_SER3);
        u_host_bus_model.spi(1'b0, 8'h96);
        take(1'b1, 8'h96);
        do_reset(`MODE_CODE_SER4);
        u_host_bus_model.spi(1'b0, 8'h69);
        take(1'b0, 8'h69);
    endtask

    // Ten writes with the core stalled: nine stored, the tenth dropped.
    task automatic t_fifo();
        do_reset(`MODE_CODE_8080);
        for (int i = 0; i < 10; i++) u_host_bus_model.wr(1'b0, 1'b1, 8'(8'h10 + i), 1'b0, 1'b0);
        check({busy, overrun}, 9'h3);
        for (int i = 0; i < 9; i++) take(1'b1, 8'(8'h10 + i));
        repeat (4) @(posedge clk);
        check({bvalid, overrun}, 9'h1);
    endtask

    // Two-wire: own address is acked and its payload stored, a foreign one is ignored.
    task automatic t_twi();
        logic [2:0] acks;
        do_reset(`MODE_CODE_TWI);
        u_host_bus_model.twi({`TWI_ADDR_HI_RESET, 2'b10, 1'b0, 8'h00, 8'he1},
            acks);
        check(acks, 3'h7);
        take(1'b0, 8'he1);
        u_host_bus_model.twi({`TWI_ADDR_HI_RESET, 2'b01, 1'b0, 8'h40, 8'h5e},
            acks);
        check({acks, bvalid}, 4'h0);
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog well beyond the roughly 1100 cycles the scenarios need.
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        t_modes();
        t_8080();
        t_6800();
        t_serial();
        t_fifo();
        t_twi();
        give_verdict();
    end
endmodule // testbench
